// file: potr_defines.svh
// Register indices, field positions, reset values and filter counts for potr_regs.
// Assumes a 32-bit Avalon-MM slave: byte address = 4 * register index.
`ifndef POTR_DEFINES_SVH
`define POTR_DEFINES_SVH

// Register indices (word offsets)
`define POTR_IDX_IRQ_EN    6'h0A
`define POTR_IDX_SUMMARY   6'h0B
`define POTR_IDX_CFG1      6'h0C
`define POTR_IDX_CFG2      6'h0D
`define POTR_IDX_OWN_STS   6'h20
`define POTR_IDX_OWN_MASK  6'h21
`define POTR_IDX_TIU_THR1  6'h22
`define POTR_IDX_TIU_THR2  6'h23
`define POTR_IDX_STATE     6'h24

// Configuration register fields
`define POTR_CFG_ALGO_BIT  7
`define POTR_CFG_TRACE_ACCEPT_COUNT_SEL_BIT  6
`define POTR_CFG_REMOTE_DEFECT_FILTER_DEPTH_BIT 3
`define POTR_CFG_PDI_MSB   2
`define POTR_CFG_PDI_LSB   0

// Reset values
`define POTR_IRQ_EN_RST    6'h00
`define POTR_PDI_RST       3'h6
`define POTR_TIU_THR_RST   8'h04

// Persistence and acceptance counts
`define POTR_RDI_CNT_LONG  4'hA
`define POTR_RDI_CNT_SHORT 4'h5
`define POTR_TRC_CNT_LONG  3'h5
`define POTR_TRC_CNT_SHORT 3'h3

`endif

// file: potr_pkg.sv
// Types for the path overhead interrupt and configuration register block.
// Assumes potr_defines.svh supplies the numeric constants.
package potr_pkg;

  // Whole state of potr_regs, registered in one flop bank
  typedef struct packed {
    logic            ack;       // Bus access in its answer cycle
    logic [7:0]      rdata;     // Read data held for the answer cycle
    logic [5:0]      irq_en;    // Sub-unit interrupt enables
    logic [5:0]      summary;   // Sub-unit pending summary
    logic [1:0]      algo;      // Unstable counting algorithm select
    logic [1:0]      trace_accept_count_sel;      // Trace acceptance count select
    logic [1:0]      remote_defect_filter_depth;     // Remote defect filter depth select
    logic [1:0][2:0] pdi_code;  // Defect indication code
    logic [1:0][7:0] tiu_thr;   // Unstable threshold
    logic [3:0]      own_sts;   // Sticky block events
    logic [3:0]      own_mask;  // Event masks
    logic [1:0]      pdi;       // Defect indication detected
    logic [1:0][2:0] rdi_cand;  // Candidate remote defect code
    logic [1:0][3:0] rdi_cnt;   // Candidate persistence
    logic [1:0][2:0] rdi_acc;   // Accepted remote defect code
    logic [1:0][2:0] trc_cnt;   // Identical trace receptions
    logic [1:0]      trc_acc;   // Trace accepted pulse
    logic [1:0]      uns_run;   // Unstable counter started
    logic [1:0][7:0] uns_cnt;   // Unstable counter
    logic [1:0]      trace_identifier_unstable;       // Trace identifier unstable
    logic            irq_n;     // Interrupt pin, active low
  } potr_state_t;

endpackage

// file: potr_regs.sv
// Interrupt summary, enables and per-unit path monitor configuration for
// path overhead processors and trace buffers, with small per-unit filters.
// Assumes all sub-unit inputs come from logic on i_clk; an Avalon-MM master.
//
// Operation
// [RL1] Enable register: six enables, reset zero
// [RL2] Masked sub-unit still flagged, pin quiet
// [RL3] Sub-unit disabled sources never reach summary
// [RL4] Read-only summary register, six flags, zero
// [RL5] Summary bit high while sub-unit pending
// [RL6] Software clears inside sub-unit, not here
// [RL7] Config registers for units one and two
// [RL8] Defect code resets to binary 110
// [RL9] Compare V5 or sign-extended C2 byte
// [RL10] Remote defect accepted after ten or five
// [RL11] Trace accepted after five or three
// [RL12] Algorithm high: count from first mismatch
// [RL13] Algorithm low: count every mismatch
// [RL14] Unstable when count exceeds threshold
// [RL15] One shared interrupt pin for enabled pending
// [RL16] Summary follows OR of enabled pending flags
// [RL17] Unused bits ignore writes, read zero
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "potr_defines.svh"

module potr_regs #(
  parameter int NUM_UNITS = 2  // Configurable units held here
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]            i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  // Enabled pending flags of the six sub-units
  input  wire logic [5:0]            i_subunit_pending,
  // Per-unit received overhead
  input  wire logic [1:0]            i_payload_tu3,
  input  wire logic [1:0]            i_v5_strobe,
  input  wire logic [1:0][2:0]       i_v5_pdi_bits,
  input  wire logic [1:0][7:0]       i_c2_byte,
  input  wire logic [1:0]            i_rdi_strobe,
  input  wire logic [1:0][2:0]       i_rdi_code,
  input  wire logic [1:0]            i_trace_strobe,
  input  wire logic [1:0]            i_trace_same,
  // Per-unit results
  output logic      [1:0]            o_path_defect_indication,
  output logic      [1:0][2:0]       o_rdi_accepted_code,
  output logic      [1:0]            o_trace_accept,
  output logic      [1:0]            o_trace_identifier_unstable,
  // Interrupt
  output logic                       o_interrupt_out_n
);

  potr_pkg::potr_state_t st_q;  // Registered state
  potr_pkg::potr_state_t st_d;  // Next state

  // Register index select, used by both read and write decode
  function automatic logic potr_sel(input logic [7:0] addr, input logic [5:0] idx);
    potr_sel = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // Defect code match; TU3 uses the code sign-extended from its top bit to a byte
  function automatic logic potr_pdi_hit(input logic tu3, input logic [2:0] code,
                                        input logic [2:0] v5, input logic [7:0] c2);
    potr_pdi_hit = tu3 ? (c2 == {{5{code[2]}}, code}) : (v5 == code);
  endfunction

  logic        req;      // Request present
  logic        wr_ok;    // Write takes effect this edge
  logic [7:0]  wdat;     // Low byte of write data
  logic [3:0]  rdi_lim [2];  // Persistence limit per unit
  logic [2:0]  trc_lim [2];  // Acceptance limit per unit

  assign req  = i_avs_read | i_avs_write;
  assign wdat = i_avs_writedata[7:0];
  // Write lands at the edge where waitrequest is low; byte lane 0 carries data
  assign wr_ok = i_avs_write & st_q.ack & i_avs_byteenable[0];

  // Wait one cycle on every access so read data comes from a flop
  assign o_avs_waitrequest = req & ~st_q.ack;
  assign o_avs_readdata    = {24'h000000, st_q.rdata};

  // Limits from the configuration bits
  always_comb begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      rdi_lim[u] = st_q.remote_defect_filter_depth[u] ? `POTR_RDI_CNT_LONG : `POTR_RDI_CNT_SHORT;  // [RL10]
      trc_lim[u] = st_q.trace_accept_count_sel[u] ? `POTR_TRC_CNT_LONG : `POTR_TRC_CNT_SHORT;   // [RL11]
    end
  end

  // Next-state logic for bus, registers, filters and interrupt
  always_comb begin
    logic [3:0] ev;   // Events raised this cycle
    logic [3:0] w1c;  // Status bits written one
    ev     = 4'h0;
    w1c    = 4'h0;
    st_d   = st_q;
    // Bus handshake: ack high for exactly the answer cycle
    st_d.ack = req & ~st_q.ack;
    // Read mux captured in the wait cycle
    if (req & ~st_q.ack) begin
      st_d.rdata = 8'h00;  // Unmapped addresses read zero
      if (potr_sel(i_avs_address, `POTR_IDX_IRQ_EN)) begin
        st_d.rdata = {2'h0, st_q.irq_en};  // [RL17]
      end else if (potr_sel(i_avs_address, `POTR_IDX_SUMMARY)) begin
        st_d.rdata = {2'h0, st_q.summary};  // [RL4]
      end else if (potr_sel(i_avs_address, `POTR_IDX_CFG1)) begin
        st_d.rdata = {st_q.algo[0], st_q.trace_accept_count_sel[0], 2'h0, st_q.remote_defect_filter_depth[0], st_q.pdi_code[0]};
      end else if (potr_sel(i_avs_address, `POTR_IDX_CFG2)) begin
        st_d.rdata = {st_q.algo[1], st_q.trace_accept_count_sel[1], 2'h0, st_q.remote_defect_filter_depth[1], st_q.pdi_code[1]};
      end else if (potr_sel(i_avs_address, `POTR_IDX_OWN_STS)) begin
        st_d.rdata = {4'h0, st_q.own_sts};
      end else if (potr_sel(i_avs_address, `POTR_IDX_OWN_MASK)) begin
        st_d.rdata = {4'h0, st_q.own_mask};
      end else if (potr_sel(i_avs_address, `POTR_IDX_TIU_THR1)) begin
        st_d.rdata = st_q.tiu_thr[0];
      end else if (potr_sel(i_avs_address, `POTR_IDX_TIU_THR2)) begin
        st_d.rdata = st_q.tiu_thr[1];
      end else if (potr_sel(i_avs_address, `POTR_IDX_STATE)) begin
        st_d.rdata = {2'h0, st_q.trace_identifier_unstable, st_q.trc_acc, st_q.pdi};
      end
    end
    // Register writes; reading the summary clears nothing
    if (wr_ok) begin
      if (potr_sel(i_avs_address, `POTR_IDX_IRQ_EN)) begin
        st_d.irq_en = wdat[5:0];  // [RL1] [RL17]
      end else if (potr_sel(i_avs_address, `POTR_IDX_CFG1)) begin
        st_d.algo[0]     = wdat[`POTR_CFG_ALGO_BIT];  // [RL7]
        st_d.trace_accept_count_sel[0]     = wdat[`POTR_CFG_TRACE_ACCEPT_COUNT_SEL_BIT];
        st_d.remote_defect_filter_depth[0]    = wdat[`POTR_CFG_REMOTE_DEFECT_FILTER_DEPTH_BIT];
        st_d.pdi_code[0] = wdat[`POTR_CFG_PDI_MSB:`POTR_CFG_PDI_LSB];
      end else if (potr_sel(i_avs_address, `POTR_IDX_CFG2)) begin
        st_d.algo[1]     = wdat[`POTR_CFG_ALGO_BIT];  // [RL7]
        st_d.trace_accept_count_sel[1]     = wdat[`POTR_CFG_TRACE_ACCEPT_COUNT_SEL_BIT];
        st_d.remote_defect_filter_depth[1]    = wdat[`POTR_CFG_REMOTE_DEFECT_FILTER_DEPTH_BIT];
        st_d.pdi_code[1] = wdat[`POTR_CFG_PDI_MSB:`POTR_CFG_PDI_LSB];
      end else if (potr_sel(i_avs_address, `POTR_IDX_OWN_STS)) begin
        w1c = wdat[3:0];
      end else if (potr_sel(i_avs_address, `POTR_IDX_OWN_MASK)) begin
        st_d.own_mask = wdat[3:0];
      end else if (potr_sel(i_avs_address, `POTR_IDX_TIU_THR1)) begin
        st_d.tiu_thr[0] = wdat;
      end else if (potr_sel(i_avs_address, `POTR_IDX_TIU_THR2)) begin
        st_d.tiu_thr[1] = wdat;
      end
    end
    // Summary tracks the sub-units' own enabled flags, so it drops when they clear
    st_d.summary = i_subunit_pending;  // [RL3] [RL5] [RL16]
    // Per-unit filters
    st_d.trc_acc = 2'h0;
    for (int u = 0; u < NUM_UNITS; u++) begin
      // Defect indication sampled on each overhead byte
      if (i_v5_strobe[u]) begin
        st_d.pdi[u] = potr_pdi_hit(i_payload_tu3[u], st_q.pdi_code[u],
                                   i_v5_pdi_bits[u], i_c2_byte[u]);  // [RL9]
      end
      // Remote defect persistence: a change restarts the run at one
      if (i_rdi_strobe[u]) begin
        if (i_rdi_code[u] != st_q.rdi_cand[u]) begin
          st_d.rdi_cand[u] = i_rdi_code[u];
          st_d.rdi_cnt[u]  = 4'h1;
        end else if (st_q.rdi_cnt[u] < rdi_lim[u]) begin
          st_d.rdi_cnt[u] = st_q.rdi_cnt[u] + 4'h1;
        end
        // Accept once the run reaches the depth
        if ((st_d.rdi_cnt[u] >= rdi_lim[u]) && (st_q.rdi_acc[u] != st_d.rdi_cand[u])) begin
          st_d.rdi_acc[u] = st_d.rdi_cand[u];  // [RL10]
          ev[2 + u]       = 1'b1;
        end
      end
      // Trace acceptance and unstable counting
      if (i_trace_strobe[u]) begin
        if (!i_trace_same[u]) begin
          st_d.trc_cnt[u] = 3'h1;
          st_d.uns_run[u] = 1'b1;
          // Both algorithms count the mismatch itself, saturating
          if (st_q.uns_cnt[u] != 8'hFF) begin
            st_d.uns_cnt[u] = st_q.uns_cnt[u] + 8'h01;  // [RL13]
          end
        end else begin
          if (st_q.trc_cnt[u] < trc_lim[u]) begin
            st_d.trc_cnt[u] = st_q.trc_cnt[u] + 3'h1;
          end
          // Once started, the high algorithm keeps counting every identifier
          if (st_q.algo[u] && st_q.uns_run[u] && (st_q.uns_cnt[u] != 8'hFF)) begin
            st_d.uns_cnt[u] = st_q.uns_cnt[u] + 8'h01;  // [RL12]
          end
          // Acceptance clears the counter under either algorithm
          if ((st_q.trc_cnt[u] + 3'h1) == trc_lim[u]) begin
            st_d.trc_acc[u] = 1'b1;  // [RL11]
            st_d.uns_cnt[u] = 8'h00;  // [RL12] [RL13]
            st_d.uns_run[u] = 1'b0;
          end
        end
      end
      st_d.trace_identifier_unstable[u] = st_d.uns_cnt[u] > st_q.tiu_thr[u];  // [RL14]
      ev[u]       = st_d.trace_identifier_unstable[u] & ~st_q.trace_identifier_unstable[u];
    end
    // Sticky events: a new event wins over a same-cycle clear
    st_d.own_sts = (st_q.own_sts & ~w1c) | ev;
    // Pin gated by the summary enables; masked sub-units stay flagged
    st_d.irq_n = ~(|(st_q.summary & st_q.irq_en) | |(st_q.own_sts & st_q.own_mask));  // [RL2] [RL15]
  end

  // State register; configuration takes its documented defaults
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q          <= '0;
      st_q.irq_en   <= `POTR_IRQ_EN_RST;  // [RL1]
      st_q.pdi_code <= {`POTR_PDI_RST, `POTR_PDI_RST};  // [RL8]
      st_q.tiu_thr  <= {`POTR_TIU_THR_RST, `POTR_TIU_THR_RST};
      st_q.irq_n    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign o_path_defect_indication    = st_q.pdi;
  assign o_rdi_accepted_code         = st_q.rdi_acc;
  assign o_trace_accept              = st_q.trc_acc;
  assign o_trace_identifier_unstable = st_q.trace_identifier_unstable;
  assign o_interrupt_out_n           = st_q.irq_n;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic own_act;  // Some unmasked block event pending
  assign own_act = |(st_q.own_sts & st_q.own_mask);

  irq_mask_a: assert property ((~|(st_q.summary & st_q.irq_en)) && !own_act  // [RL2]
    |=> o_interrupt_out_n) else $error("interrupt pin low with nothing enabled");
  irq_pin_a: assert property ((|(st_q.summary & st_q.irq_en))  // [RL15]
    |=> !o_interrupt_out_n) else $error("interrupt pin not low for enabled summary");
  summary_follow_a: assert property (i_subunit_pending != $past(i_subunit_pending)  // [RL16]
    |=> st_q.summary == $past(i_subunit_pending)) else $error("summary not following");
  en_write_a: assert property (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]  // [RL1]
    && potr_sel(i_avs_address, `POTR_IDX_IRQ_EN) |=> st_q.irq_en == $past(wdat[5:0]))
    else $error("enable write lost");
  summary_ro_a: assert property (i_avs_read && !o_avs_waitrequest  // [RL4]
    && potr_sel(i_avs_address, `POTR_IDX_SUMMARY)
    |-> o_avs_readdata[7:6] == 2'h0 && o_avs_readdata[5:0] == $past(st_q.summary))
    else $error("summary read wrong");
  cfg_unused_a: assert property (i_avs_read && !o_avs_waitrequest  // [RL17]
    && potr_sel(i_avs_address, `POTR_IDX_CFG1) |-> o_avs_readdata[5:4] == 2'h0)
    else $error("unused config bits not zero");
  wait_one_a: assert property ($rose(i_avs_read) && !st_q.ack
    |-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("answer not after one wait");
  // The defect code keeps its default until software writes the register
  cfg_keep_a: assert property (!(wr_ok && potr_sel(i_avs_address, `POTR_IDX_CFG1))  // [RL8]
    |=> $stable(st_q.pdi_code[0])) else $error("defect code changed without a write");

  // Per-unit filter checks; expectations are rebuilt from the inputs and registered state, not the next-state logic
  for (genvar g = 0; g < NUM_UNITS; g++) begin : g_chk
    pdi_v5_a: assert property (i_v5_strobe[g] && !i_payload_tu3[g]  // [RL9]
      |=> o_path_defect_indication[g] == ($past(i_v5_pdi_bits[g]) == $past(st_q.pdi_code[g])))
      else $error("defect indication compare wrong");
    rdi_depth_a: assert property ($changed(o_rdi_accepted_code[g])  // [RL10]
      |-> st_q.rdi_cnt[g] == $past(rdi_lim[g])) else $error("remote defect accepted early");
    trc_accept_a: assert property (o_trace_accept[g]  // [RL11]
      |-> st_q.uns_cnt[g] == 8'h00 && st_q.trc_cnt[g] == $past(trc_lim[g]))
      else $error("trace accept count wrong");
    tiu_thr_a: assert property (o_trace_identifier_unstable[g]  // [RL14]
      == (st_q.uns_cnt[g] > $past(st_q.tiu_thr[g]))) else $error("unstable flag wrong");
    low_algo_a: assert property (!st_q.algo[g] && i_trace_strobe[g] && i_trace_same[g]  // [RL13]
      |=> st_q.uns_cnt[g] <= $past(st_q.uns_cnt[g])) else $error("low algorithm counted match");
    // TU3 compares the whole byte, code top bit copied into the upper five bits
    pdi_c2_a: assert property (i_v5_strobe[g] && i_payload_tu3[g]  // [RL9]
      |=> o_path_defect_indication[g] == ($past(i_c2_byte[g])
          == {{5{$past(st_q.pdi_code[g][2])}}, $past(st_q.pdi_code[g])}))
      else $error("byte defect indication compare wrong");
    // Every dissimilar identifier counts once, whatever the algorithm
    mis_count_a: assert property (i_trace_strobe[g] && !i_trace_same[g]  // [RL13]
      && (st_q.uns_cnt[g] != 8'hFF)
      |=> st_q.uns_cnt[g] == $past(st_q.uns_cnt[g]) + 8'h01)
      else $error("unstable count missed a mismatch");
    // Once started, the high algorithm counts repeats too until acceptance
    high_algo_a: assert property (st_q.algo[g] && st_q.uns_run[g] && i_trace_strobe[g]  // [RL12]
      && i_trace_same[g] && (st_q.uns_cnt[g] != 8'hFF)
      && ((st_q.trc_cnt[g] + 3'h1) != trc_lim[g])
      |=> st_q.uns_cnt[g] == $past(st_q.uns_cnt[g]) + 8'h01)
      else $error("high algorithm stopped counting");
  end

  irq_seen_c: cover property (!o_interrupt_out_n ##[1:20] o_interrupt_out_n);
  tiu_seen_c: cover property (o_trace_identifier_unstable[0] ##[1:50] o_trace_accept[0]);
  rdi_seen_c: cover property ($changed(o_rdi_accepted_code[1]));
  algo_hi_c: cover property (st_q.algo[0] && o_trace_identifier_unstable[0]);

endmodule

// file: tb_potr_regs.sv
// Self-checking bench for potr_regs: register bus, interrupt summary and unit filters.
// Assumes an Avalon-MM slave that may insert any number of wait states.
`timescale 1ns/100ps
`include "potr_defines.svh"

module tb_potr_regs;
  // Clock, reset and design ports
  logic             i_clk;
  logic             i_rst_n;
  logic [7:0]       i_avs_address;
  logic             i_avs_read;
  logic             i_avs_write;
  logic [31:0]      i_avs_writedata;
  logic [3:0]       i_avs_byteenable;
  logic [31:0]      o_avs_readdata;
  logic             o_avs_waitrequest;
  logic [5:0]       i_subunit_pending;
  logic [1:0]       i_payload_tu3;
  logic [1:0]       i_v5_strobe;
  logic [1:0][2:0]  i_v5_pdi_bits;
  logic [1:0][7:0]  i_c2_byte;
  logic [1:0]       i_rdi_strobe;
  logic [1:0][2:0]  i_rdi_code;
  logic [1:0]       i_trace_strobe;
  logic [1:0]       i_trace_same;
  logic [1:0]       o_path_defect_indication;
  logic [1:0][2:0]  o_rdi_accepted_code;
  logic [1:0]       o_trace_accept;
  logic [1:0]       o_trace_identifier_unstable;
  logic             o_interrupt_out_n;
  // Bench bookkeeping
  int               n_errors;
  int               tests_run;
  int               cycles;
  int               seed;
  logic [31:0]      exp_q[$];   // Expected read data, oldest first
  logic [5:0]       en;
  logic [5:0]       pend;

  potr_regs potr_regs_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_subunit_pending(i_subunit_pending),
    .i_payload_tu3(i_payload_tu3), .i_v5_strobe(i_v5_strobe), .i_v5_pdi_bits(i_v5_pdi_bits),
    .i_c2_byte(i_c2_byte), .i_rdi_strobe(i_rdi_strobe), .i_rdi_code(i_rdi_code),
    .i_trace_strobe(i_trace_strobe), .i_trace_same(i_trace_same),
    .o_path_defect_indication(o_path_defect_indication),
    .o_rdi_accepted_code(o_rdi_accepted_code), .o_trace_accept(o_trace_accept),
    .o_trace_identifier_unstable(o_trace_identifier_unstable),
    .o_interrupt_out_n(o_interrupt_out_n));

  // 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Single comparison point; every result passes through here
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      stop_test();
    end
  end

  // Read monitor: data is taken at the rising edge where waitrequest is sampled low
  always @(posedge i_clk) begin
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0)
        check(o_avs_readdata, 32'hFFFFFFFF);
      else
        check(o_avs_readdata, exp_q.pop_front());
    end
  end

  // One bus access by word index; a read notes its expected byte first
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge i_clk);
    i_avs_address    <= {idx, 2'b00};
    i_avs_read       <= ~wr;
    i_avs_write      <= wr;
    i_avs_writedata  <= {24'h000000, wr ? d : 8'h00};
    i_avs_byteenable <= be;
    if (!wr)
      exp_q.push_back({24'h000000, d});
    // Hold everything until waitrequest is sampled low; only the hang guard ends a stuck wait
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  // One strobe on unit u: kind 0 defect sample, 1 remote defect code, 2 trace
  task strobe(input int kind, input int u, input logic [7:0] v);
    @(posedge i_clk);
    case (kind)
      0: begin
        i_v5_pdi_bits[u] <= v[2:0];
        i_c2_byte[u]     <= v;
        i_v5_strobe[u]   <= 1'b1;
      end
      1: begin
        i_rdi_code[u]   <= v[2:0];
        i_rdi_strobe[u] <= 1'b1;
      end
      default: begin
        i_trace_same[u]   <= v[0];
        i_trace_strobe[u] <= 1'b1;
      end
    endcase
    @(posedge i_clk);
    i_v5_strobe    <= 2'b00;
    i_rdi_strobe   <= 2'b00;
    i_trace_strobe <= 2'b00;
    @(posedge i_clk);
  endtask

  initial begin
    seed = 31;
    i_rst_n = 1'b0;
    {i_avs_address, i_avs_read, i_avs_write, i_avs_writedata} = '0;
    i_avs_byteenable = 4'hF;
    {i_subunit_pending, i_payload_tu3, i_v5_strobe, i_v5_pdi_bits, i_c2_byte} = '0;
    {i_rdi_strobe, i_rdi_code, i_trace_strobe, i_trace_same} = '0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // Reset values and access kinds
    bus(0, `POTR_IDX_IRQ_EN, 8'h00, 4'hF);
    bus(0, `POTR_IDX_SUMMARY, 8'h00, 4'hF);
    bus(0, `POTR_IDX_CFG1, 8'h06, 4'hF);
    bus(0, `POTR_IDX_CFG2, 8'h06, 4'hF);
    check({31'h0, o_interrupt_out_n}, 32'h1);
    bus(1, `POTR_IDX_IRQ_EN, 8'hFF, 4'hF);
    bus(0, `POTR_IDX_IRQ_EN, 8'h3F, 4'hF);
    bus(1, `POTR_IDX_CFG2, 8'hFF, 4'hF);
    bus(0, `POTR_IDX_CFG2, 8'hCF, 4'hF);
    bus(1, `POTR_IDX_CFG2, 8'h00, 4'h0);
    bus(0, `POTR_IDX_CFG2, 8'hCF, 4'hF);
    bus(1, `POTR_IDX_SUMMARY, 8'h3F, 4'hF);
    bus(0, `POTR_IDX_SUMMARY, 8'h00, 4'hF);
    bus(0, 6'h0E, 8'h00, 4'hF);
    bus(1, `POTR_IDX_CFG2, 8'h06, 4'hF);
    // Summary follows pending, pin only for enabled ones, reads do not clear
    repeat (8) begin
      en   = 6'($random(seed));
      pend = 6'($random(seed));
      bus(1, `POTR_IDX_IRQ_EN, {2'b00, en}, 4'hF);
      i_subunit_pending <= pend;
      repeat (3) @(posedge i_clk);
      bus(0, `POTR_IDX_SUMMARY, {2'b00, pend}, 4'hF);
      bus(0, `POTR_IDX_SUMMARY, {2'b00, pend}, 4'hF);
      check({31'h0, o_interrupt_out_n}, {31'h0, ~|(pend & en)});
    end
    i_subunit_pending <= 6'h00;
    repeat (3) @(posedge i_clk);
    bus(0, `POTR_IDX_SUMMARY, 8'h00, 4'hF);
    check({31'h0, o_interrupt_out_n}, 32'h1);
    // Defect code compare, V5 bits or sign-extended C2 byte, both units
    for (int u = 0; u < 2; u++) begin
      i_payload_tu3 <= 2'b00;
      strobe(0, u, 8'h06);
      check(o_path_defect_indication[u], 1'b1);
      strobe(0, u, 8'h07);
      check(o_path_defect_indication[u], 1'b0);
      i_payload_tu3 <= 2'b11;
      strobe(0, u, 8'hFE);
      check(o_path_defect_indication[u], 1'b1);
      strobe(0, u, 8'h06);
      check(o_path_defect_indication[u], 1'b0);
    end
    bus(1, `POTR_IDX_CFG1, 8'h03, 4'hF);
    strobe(0, 0, 8'h03);
    check(o_path_defect_indication[0], 1'b1);
    // Remote defect filter: five when depth is low, ten when high
    for (int d = 0; d < 2; d++) begin
      bus(1, `POTR_IDX_CFG1, d ? 8'h0E : 8'h06, 4'hF);
      for (int n = 1; n <= (d ? 10 : 5); n++) begin
        strobe(1, 0, d ? 8'h02 : 8'h05);
        check(o_rdi_accepted_code[0], (n == (d ? 10 : 5)) ? (d ? 3'h2 : 3'h5)
                                         : (d ? 3'h5 : 3'h0));
      end
    end
    // Trace acceptance: three when low, five when high; pulse lasts one cycle
    for (int p = 0; p < 2; p++) begin
      bus(1, `POTR_IDX_CFG1, p ? 8'h46 : 8'h06, 4'hF);
      strobe(2, 0, 8'h00);
      for (int n = 2; n <= (p ? 5 : 3); n++) begin
        strobe(2, 0, 8'h01);
        check(o_trace_accept[0], n == (p ? 5 : 3));
      end
      @(posedge i_clk);
      check(o_trace_accept[0], 1'b0);
    end
    // Unit two: remote defect, mismatch counting and acceptance
    for (int n = 1; n <= 5; n++) begin
      strobe(1, 1, 8'h03);
      check(o_rdi_accepted_code[1], (n == 5) ? 3'h3 : 3'h0);
      strobe(2, 1, 8'h00);
      check(o_trace_identifier_unstable[1], n > 4);
    end
    strobe(2, 1, 8'h01);
    strobe(2, 1, 8'h01);
    check(o_trace_accept[1], 1'b1);
    check(o_trace_identifier_unstable[1], 1'b0);
    // Unstable, algorithm low: every mismatch counts, threshold 4 by default
    bus(1, `POTR_IDX_OWN_STS, 8'h0F, 4'hF);
    bus(1, `POTR_IDX_CFG1, 8'h06, 4'hF);
    for (int n = 1; n <= 5; n++) begin
      strobe(2, 0, 8'h00);
      check(o_trace_identifier_unstable[0], n > 4);
    end
    repeat (3) @(posedge i_clk);
    check({31'h0, o_interrupt_out_n}, 32'h1);
    bus(0, `POTR_IDX_OWN_STS, 8'h01, 4'hF);
    bus(1, `POTR_IDX_OWN_MASK, 8'h01, 4'hF);
    repeat (3) @(posedge i_clk);
    check({31'h0, o_interrupt_out_n}, 32'h0);
    bus(1, `POTR_IDX_OWN_STS, 8'h01, 4'hF);
    repeat (3) @(posedge i_clk);
    check({31'h0, o_interrupt_out_n}, 32'h1);
    strobe(2, 0, 8'h01);
    strobe(2, 0, 8'h01);
    check(o_trace_identifier_unstable[0], 1'b0);
    // Unstable, algorithm high: counting runs on after the first mismatch
    bus(1, `POTR_IDX_TIU_THR1, 8'h02, 4'hF);
    bus(1, `POTR_IDX_CFG1, 8'hC6, 4'hF);
    strobe(2, 0, 8'h00);
    strobe(2, 0, 8'h01);
    check(o_trace_identifier_unstable[0], 1'b0);
    strobe(2, 0, 8'h01);
    check(o_trace_identifier_unstable[0], 1'b1);
    strobe(2, 0, 8'h01);
    strobe(2, 0, 8'h01);
    check(o_trace_identifier_unstable[0], 1'b0);
    repeat (4) @(posedge i_clk);
    check(exp_q.size(), 32'h0);
    stop_test();
  end
endmodule
